/* core/gpio_port_pkg.sv */
package gpio_port_pkg;

    // ********************************************************
    // Bus and decode
    // ********************************************************
    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam logic [15:0] BASE_BLOCKING = 16'h0200;
    localparam logic [15:0] BASE_NONBLOCKING = 16'h0300;
    localparam logic [15:0] BASE_MASK = 16'hff00;
    localparam logic [7:0] OFF_CTRL = 8'h40;
    localparam logic [7:0] OFF_PULL = 8'h42;
    localparam logic [7:0] OFF_LEVEL = 8'h43;
    localparam logic [7:0] OFF_PIN0_ROUTE = 8'h44;
    localparam logic [7:0] OFF_PIN3_ROUTE = 8'h4a;

    // ********************************************************
    // Field positions
    // ********************************************************
    localparam int NUM_PINS = 4;
    localparam int NUM_IO = 3;
    localparam int NUM_CAP = 4;
    localparam int CTRL_EN_LSB = 0;
    localparam int CTRL_DIR_LSB = 4;
    localparam int CTRL_EN_MASK_LSB = 8;
    localparam int CTRL_DIR_MASK_LSB = 12;
    localparam int PULL_UP_LSB = 0;
    localparam int PULL_DOWN_BIT = 3;
    localparam int ROUTE_LIN_BIT = 1;
    localparam int ROUTE_SCI_BIT = 2;
    localparam int ROUTE_CAP_LSB = 3;
    localparam int PIN3_WAKE_BIT = 7;
    localparam int PIN3_INDEX = 3;

    // ********************************************************
    // Writable masks and reset values
    // ********************************************************
    localparam logic [7:0] PULL_WMASK = 8'h0f;
    localparam logic [7:0] ROUTE0_WMASK = 8'h7e;
    localparam logic [7:0] PIN3_WMASK = 8'h80;
    localparam logic [3:0] EN_RESET = 4'h0;
    localparam logic [2:0] DIR_RESET = 3'h0;
    localparam logic [7:0] PULL_RESET = 8'h00;
    localparam logic [7:0] ROUTE0_RESET = 8'h00;
    localparam logic [7:0] PIN3_RESET = 8'h00;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int SYNC_STAGES = 2;

endpackage

/* core/pin_sync.sv */
`timescale 1ns/10ps
module pin_sync
    import gpio_port_pkg::*;
#(
    parameter int WIDTH = NUM_PINS,
    parameter int STAGES = SYNC_STAGES
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    // Fewer than two stages would not settle metastability
    if (STAGES < 2 || WIDTH < 1) begin : g_bad_params
        $error("pin_sync: unsupported parameters");
    end

    logic [WIDTH-1:0] stage_reg [STAGES];
    logic [WIDTH-1:0] stage_next [STAGES];

    always_comb begin
        stage_next[0] = i_async;
        for (int s = 1; s < STAGES; s++) begin
            stage_next[s] = stage_reg[s-1];
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            for (int s = 0; s < STAGES; s++) begin
                stage_reg[s] <= '0;
            end
        end else if (i_clk_en) begin
            stage_reg <= stage_next;
        end
    end

    assign o_sync = stage_reg[STAGES-1];

endmodule // pin_sync

/* core/gpio_port_config_regs.sv */
// Summary of operation
// - The direction and enable control register is reached only by whole 16-bit accesses.
// - A direction bit changes on a write only when its direction mask bit is set in that word.
// - An enable bit changes on a write only when its enable mask bit is set in that word.
// - Direction zero makes pins 0 to 2 inputs and direction one makes them outputs.
// - A cleared enable leaves the pin floating; set, pins 0 to 2 are I/O and pin 3 input only.
// - Port logic keeps running whatever the enables; an enable only joins it to the pad buffer.
// - Pull bit 3 switches the pin 3 pull-down on or off.
// - Pull bits 2 to 0 switch the pull-ups of pins 2 to 0 on or off.
// - The level register reads the pin buffers in bits 3 to 0 and ignores writes.
// - In normal mode pin 3 reads back only while its wake/read enable is set.
// - Routing bits 6 to 3 send pin 0 to capture channels 3 to 0.
// - Routing bit 2 sends pin 0 to the serial receiver input.
// - Routing bit 1 sends pin 0 to the LIN transmit input.
// - Offsets decode against base 0x0200 for blocking and 0x300 for non-blocking access.
// - Full port function exists only in normal mode; low power keeps the pin 3 buffer, the pull settings and register access.
//
// Implementation choice: the strobed register port.
`timescale 1ns/10ps
module gpio_port_config_regs
    import gpio_port_pkg::*;
#(
    parameter int ADDR_WIDTH = ADDR_W
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_clk_en,
    input wire logic [ADDR_WIDTH-1:0] i_addr,
    input wire logic [DATA_W-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_word_access,
    output logic [DATA_W-1:0] o_rdata,
    input wire logic i_normal_mode,
    input wire logic [NUM_PINS-1:0] i_port_pin_in,
    input wire logic [NUM_IO-1:0] i_port_out_value,
    output logic [NUM_IO-1:0] o_port_pin_out,
    output logic [NUM_IO-1:0] o_port_pin_oe,
    output logic [NUM_PINS-1:0] o_pin_buffer_connect,
    output logic [NUM_IO-1:0] o_pin_direction,
    output logic [NUM_IO-1:0] o_pullup_on,
    output logic o_pin3_pulldown_on,
    output logic [NUM_CAP-1:0] o_capture_in,
    output logic o_serial_rx,
    output logic o_lin_tx_in
);

    // ********************************************************
    // Elaboration checks
    // ********************************************************
    // Both bases need address bits 9 and 8 to be present
    if (ADDR_WIDTH < 10 || ADDR_WIDTH > ADDR_W) begin : g_bad_addr_width
        $error("gpio_port_config_regs: unsupported address width");
    end

    // ********************************************************
    // Functions
    // ********************************************************
    function automatic logic reg_hit(input logic [ADDR_WIDTH-1:0] addr,
                                     input logic [7:0] off);
        logic [15:0] full;
        full = 16'(addr);
        reg_hit = (full[7:0] == off) &&
                  (((full & BASE_MASK) == BASE_BLOCKING) ||
                   ((full & BASE_MASK) == BASE_NONBLOCKING));
    endfunction

    // Mask bit one takes the new bit, mask bit zero keeps the old
    function automatic logic [3:0] masked_update(input logic [3:0] old_val,
                                                 input logic [3:0] new_val,
                                                 input logic [3:0] mask);
        masked_update = (old_val & ~mask) | (new_val & mask);
    endfunction

    // ********************************************************
    // Decode
    // ********************************************************
    logic hit_ctrl;
    logic hit_pull;
    logic hit_level;
    logic hit_route0;
    logic hit_route3;
    logic ctrl_write;

    assign hit_ctrl = reg_hit(i_addr, OFF_CTRL);
    assign hit_pull = reg_hit(i_addr, OFF_PULL);
    assign hit_level = reg_hit(i_addr, OFF_LEVEL);
    assign hit_route0 = reg_hit(i_addr, OFF_PIN0_ROUTE);
    assign hit_route3 = reg_hit(i_addr, OFF_PIN3_ROUTE);
    // Byte writes to the control word are dropped, not half-applied
    assign ctrl_write = i_wr && i_word_access && hit_ctrl;

    // ********************************************************
    // Configuration registers
    // ********************************************************
    logic [3:0] enable_reg;
    logic [3:0] enable_next;
    logic [2:0] direction_reg;
    logic [2:0] direction_next;
    logic [7:0] pull_reg;
    logic [7:0] pull_next;
    logic [7:0] route0_reg;
    logic [7:0] route0_next;
    logic [7:0] route3_reg;
    logic [7:0] route3_next;

    always_comb begin
        enable_next = enable_reg;
        direction_next = direction_reg;
        pull_next = pull_reg;
        route0_next = route0_reg;
        route3_next = route3_reg;
        if (ctrl_write) begin
            enable_next = masked_update(enable_reg,
                                        i_wdata[CTRL_EN_LSB +: 4],
                                        i_wdata[CTRL_EN_MASK_LSB +: 4]);
            direction_next = 3'(masked_update({1'b0, direction_reg},
                                              {1'b0, i_wdata[CTRL_DIR_LSB +: 3]},
                                              {1'b0, i_wdata[CTRL_DIR_MASK_LSB +: 3]}));
        end
        if (i_wr && hit_pull) begin
            pull_next = i_wdata[7:0] & PULL_WMASK;
        end
        if (i_wr && hit_route0) begin
            route0_next = i_wdata[7:0] & ROUTE0_WMASK;
        end
        if (i_wr && hit_route3) begin
            route3_next = i_wdata[7:0] & PIN3_WMASK;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            enable_reg <= EN_RESET;
            direction_reg <= DIR_RESET;
            pull_reg <= PULL_RESET;
            route0_reg <= ROUTE0_RESET;
            route3_reg <= PIN3_RESET;
        end else if (i_clk_en) begin
            enable_reg <= enable_next;
            direction_reg <= direction_next;
            pull_reg <= pull_next;
            route0_reg <= route0_next;
            route3_reg <= route3_next;
        end
    end

    // ********************************************************
    // Pad side
    // ********************************************************
    logic [NUM_PINS-1:0] pin_sync_q;
    logic [NUM_PINS-1:0] buffer_connect;
    logic [NUM_PINS-1:0] pin_level;
    logic pin3_readable;

    pin_sync #(
        .WIDTH(NUM_PINS),
        .STAGES(SYNC_STAGES)
    ) u_pin_sync (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en),
        .i_async(i_port_pin_in),
        .o_sync(pin_sync_q)
    );

    // Low power drops the buffers; only pin 3 stays for wake-up
    always_comb begin
        buffer_connect = enable_reg & {NUM_PINS{i_normal_mode}};
        buffer_connect[PIN3_INDEX] = enable_reg[PIN3_INDEX];
    end

    // Pin 3 sits behind its clamp and in normal mode reads only with the wake enable
    assign pin3_readable = route3_reg[PIN3_WAKE_BIT] || !i_normal_mode;
    always_comb begin
        pin_level = pin_sync_q & buffer_connect;
        pin_level[PIN3_INDEX] = pin_sync_q[PIN3_INDEX] &&
                                buffer_connect[PIN3_INDEX] && pin3_readable;
    end

    assign o_pin_buffer_connect = buffer_connect;
    assign o_pin_direction = direction_reg;
    // Pin 3 has no output driver at all
    assign o_port_pin_oe = direction_reg & buffer_connect[NUM_IO-1:0];
    assign o_pullup_on = pull_reg[PULL_UP_LSB +: NUM_IO];
    assign o_pin3_pulldown_on = pull_reg[PULL_DOWN_BIT];

    // ********************************************************
    // Output data and input routing
    // ********************************************************
    logic [NUM_IO-1:0] pin_out_reg;
    logic [NUM_IO-1:0] pin_out_next;
    logic [NUM_CAP-1:0] capture_reg;
    logic [NUM_CAP-1:0] capture_next;
    logic serial_rx_reg;
    logic serial_rx_next;
    logic lin_tx_reg;
    logic lin_tx_next;

    // Out value is computed even while the pin is disabled
    always_comb begin
        pin_out_next = i_port_out_value;
        capture_next = route0_reg[ROUTE_CAP_LSB +: NUM_CAP] & {NUM_CAP{pin_level[0]}};
        serial_rx_next = route0_reg[ROUTE_SCI_BIT] && pin_level[0];
        lin_tx_next = route0_reg[ROUTE_LIN_BIT] && pin_level[0];
        if (!i_normal_mode) begin
            capture_next = '0;
            serial_rx_next = 1'b0;
            lin_tx_next = 1'b0;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pin_out_reg <= '0;
            capture_reg <= '0;
            serial_rx_reg <= 1'b0;
            lin_tx_reg <= 1'b0;
        end else if (i_clk_en) begin
            pin_out_reg <= pin_out_next;
            capture_reg <= capture_next;
            serial_rx_reg <= serial_rx_next;
            lin_tx_reg <= lin_tx_next;
        end
    end

    assign o_port_pin_out = pin_out_reg;
    assign o_capture_in = capture_reg;
    assign o_serial_rx = serial_rx_reg;
    assign o_lin_tx_in = lin_tx_reg;

    // ********************************************************
    // Read path
    // ********************************************************
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    // Data stands only in the cycle after the strobe, zero otherwise
    always_comb begin
        rdata_next = '0;
        if (i_rd) begin
            if (hit_ctrl && i_word_access) begin
                rdata_next[CTRL_EN_LSB +: 4] = enable_reg;
                rdata_next[CTRL_DIR_LSB +: 3] = direction_reg;
            end else if (hit_pull) begin
                rdata_next[7:0] = pull_reg;
            end else if (hit_level) begin
                rdata_next[NUM_PINS-1:0] = pin_level;
            end else if (hit_route0) begin
                rdata_next[7:0] = route0_reg;
            end else if (hit_route3) begin
                rdata_next[7:0] = route3_reg;
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            rdata_reg <= '0;
        end else if (i_clk_en) begin
            rdata_reg <= rdata_next;
        end
    end

    assign o_rdata = rdata_reg;

    // ********************************************************
    // Assertions
    // ********************************************************
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!i_reset_n);

    sequence s_ctrl_word_write;
        i_clk_en && i_wr && i_word_access && hit_ctrl;
    endsequence

    property p_dir_masked;
        s_ctrl_word_write ##0 (i_wdata[CTRL_DIR_MASK_LSB +: 3] == 3'h0)
            |=> $stable(direction_reg);
    endproperty
    a_dir_masked: assert property (p_dir_masked)
        else $error("direction changed without mask");

    property p_dir_written;
        s_ctrl_word_write ##0 (i_wdata[CTRL_DIR_MASK_LSB +: 3] == 3'h7)
            |=> (direction_reg == $past(i_wdata[CTRL_DIR_LSB +: 3]));
    endproperty
    a_dir_written: assert property (p_dir_written)
        else $error("direction not taken under full mask");

    property p_en_masked;
        s_ctrl_word_write |=> (((enable_reg ^ $past(enable_reg)) &
                               ~$past(i_wdata[CTRL_EN_MASK_LSB +: 4])) == 4'h0);
    endproperty
    a_en_masked: assert property (p_en_masked)
        else $error("enable bit changed with mask clear");

    property p_byte_ctrl_ignored;
        (i_clk_en && i_wr && !i_word_access && hit_ctrl)
            |=> $stable(enable_reg) && $stable(direction_reg);
    endproperty
    a_byte_ctrl_ignored: assert property (p_byte_ctrl_ignored)
        else $error("byte write reached control word");

    property p_oe_needs_output;
        (o_port_pin_oe & ~(direction_reg & enable_reg[NUM_IO-1:0])) == 3'h0;
    endproperty
    a_oe_needs_output: assert property (p_oe_needs_output)
        else $error("pin driven while input or disabled");

    property p_low_power_quiet;
        !i_normal_mode |-> (o_port_pin_oe == 3'h0);
    endproperty
    a_low_power_quiet: assert property (p_low_power_quiet)
        else $error("pin driven in low power mode");

    property p_pull_follows;
        (i_clk_en && i_wr && hit_pull) |=>
            (o_pullup_on == $past(i_wdata[2:0])) &&
            (o_pin3_pulldown_on == $past(i_wdata[PULL_DOWN_BIT]));
    endproperty
    a_pull_follows: assert property (p_pull_follows)
        else $error("pull outputs do not follow write");

    sequence s_level_read;
        i_clk_en && i_rd && hit_level;
    endsequence

    property p_level_read;
        s_level_read |=> (o_rdata[DATA_W-1:NUM_PINS] == '0) &&
                         (o_rdata[2:0] == $past(pin_level[2:0]));
    endproperty
    a_level_read: assert property (p_level_read)
        else $error("level readback wrong");

    property p_pin3_hidden;
        s_level_read ##0 (i_normal_mode && !route3_reg[PIN3_WAKE_BIT])
            |=> (o_rdata[PIN3_INDEX] == 1'b0);
    endproperty
    a_pin3_hidden: assert property (p_pin3_hidden)
        else $error("pin 3 visible without wake enable");

    property p_capture_route;
        i_clk_en |=> ((o_capture_in & ~$past(route0_reg[ROUTE_CAP_LSB +: NUM_CAP])) == 4'h0);
    endproperty
    a_capture_route: assert property (p_capture_route)
        else $error("capture fed without route bit");

    property p_serial_lin_route;
        (i_clk_en && i_normal_mode) |=>
            (o_serial_rx == ($past(route0_reg[ROUTE_SCI_BIT]) && $past(pin_level[0]))) &&
            (o_lin_tx_in == ($past(route0_reg[ROUTE_LIN_BIT]) && $past(pin_level[0])));
    endproperty
    a_serial_lin_route: assert property (p_serial_lin_route)
        else $error("serial or LIN routing wrong");

    property p_unmapped_zero;
        (i_clk_en && i_rd && !(hit_ctrl || hit_pull || hit_level || hit_route0 || hit_route3))
            |=> (o_rdata == '0);
    endproperty
    a_unmapped_zero: assert property (p_unmapped_zero)
        else $error("unmapped read returned data");

endmodule // gpio_port_config_regs

/* test/pin_pad_model.sv */
`timescale 1ns/10ps
module pin_pad_model (
    input wire logic i_ref_clk,
    input wire logic [3:0] i_ext_level,
    input wire logic [3:0] i_ext_drive,
    input wire logic [2:0] i_out,
    input wire logic [2:0] i_oe,
    input wire logic [3:0] i_connect,
    input wire logic [2:0] i_pullup_on,
    input wire logic i_pulldown_on,
    output logic [3:0] o_pad
);
    // ****************
    // Pad resolution
    // ****************
    logic float_reg = 1'b0;
    logic [3:0] drive4;
    logic [3:0] out4;
    logic [3:0] up4;

    // Pin 3 has no driver and no pull-up, so its slots stay zero
    assign drive4 = {1'b0, i_oe & i_connect[2:0]};
    assign out4 = {1'b0, i_out};
    assign up4 = {1'b0, i_pullup_on};

    // Floating pad toggles so a stale level never passes
    always_ff @(posedge i_ref_clk) begin
        float_reg <= ~float_reg;
    end

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (drive4[i]) begin
                o_pad[i] = out4[i];
            end else if (i_ext_drive[i]) begin
                o_pad[i] = i_ext_level[i];
            end else if (up4[i]) begin
                o_pad[i] = 1'b1;
            end else if (i == 3 && i_pulldown_on) begin
                o_pad[i] = 1'b0;
            end else begin
                o_pad[i] = float_reg ^ i[0];
            end
        end
    end
endmodule // pin_pad_model

/* test/gpio_port_config_regs_bench.sv */
`timescale 1ns/10ps
module gpio_port_config_regs_bench;
    import gpio_port_pkg::*;
    // ****************
    // Signals
    // ****************
    logic i_ref_clk = 1'b0;
    logic i_reset_n = 1'b0;
    logic i_clk_en = 1'b1;
    logic [15:0] i_addr = 16'h0000;
    logic [15:0] i_wdata = 16'h0000;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic i_word_access = 1'b1;
    logic [15:0] o_rdata;
    logic i_normal_mode = 1'b1;
    logic [3:0] pad;
    logic [2:0] i_port_out_value = 3'h0;
    logic [2:0] o_port_pin_out, o_port_pin_oe, o_pin_direction, o_pullup_on;
    logic [3:0] o_pin_buffer_connect, o_capture_in;
    logic o_pin3_pulldown_on, o_serial_rx, o_lin_tx_in;
    logic [3:0] ext_level = 4'h0;
    logic [3:0] ext_drive = 4'h0;
    int miscompares = 0;
    int check_count = 0;
    int cycles = 0;
    logic [15:0] ce = 16'h0000;
    logic [15:0] words [6] = '{16'h007f, 16'h7f7f, 16'h2000, 16'h0400, 16'h5a05, 16'h0f00};
    logic [3:0] ec;

    always #20 i_ref_clk = ~i_ref_clk;

    gpio_port_config_regs gpio_port_config_regs_i (.i_ref_clk(i_ref_clk), .i_reset_n(i_reset_n),
        .i_clk_en(i_clk_en), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd),
        .i_word_access(i_word_access), .o_rdata(o_rdata), .i_normal_mode(i_normal_mode),
        .i_port_pin_in(pad), .i_port_out_value(i_port_out_value),
        .o_port_pin_out(o_port_pin_out), .o_port_pin_oe(o_port_pin_oe),
        .o_pin_buffer_connect(o_pin_buffer_connect), .o_pin_direction(o_pin_direction),
        .o_pullup_on(o_pullup_on), .o_pin3_pulldown_on(o_pin3_pulldown_on),
        .o_capture_in(o_capture_in), .o_serial_rx(o_serial_rx), .o_lin_tx_in(o_lin_tx_in));

    pin_pad_model pin_pad_model_i (.i_ref_clk(i_ref_clk), .i_ext_level(ext_level),
        .i_ext_drive(ext_drive), .i_out(o_port_pin_out), .i_oe(o_port_pin_oe),
        .i_connect(o_pin_buffer_connect), .i_pullup_on(o_pullup_on),
        .i_pulldown_on(o_pin3_pulldown_on), .o_pad(pad));

    // ****************
    // Helpers
    // ****************
    function automatic logic [15:0] ad(input logic [15:0] base, input logic [7:0] off);
        return base | {8'h00, off};
    endfunction

    function automatic logic [15:0] ctrl_apply(input logic [15:0] cur, input logic [15:0] d);
        logic [15:0] r;
        r = cur;
        for (int i = 0; i < 4; i++) begin
            if (d[8 + i]) r[i] = d[i];
        end
        for (int j = 0; j < 3; j++) begin
            if (d[12 + j]) r[4 + j] = d[4 + j];
        end
        return r;
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic w = 1'b1);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_wdata <= d;
        i_word_access <= w;
        i_wr <= 1'b1;
        @(posedge i_ref_clk);
        i_wr <= 1'b0;
        #1;
    endtask

    // Read data stand only in the cycle after the strobe edge
    task automatic rdchk(input logic [15:0] a, input logic [15:0] exp, input logic w = 1'b1);
        @(posedge i_ref_clk);
        i_addr <= a;
        i_word_access <= w;
        i_rd <= 1'b1;
        @(posedge i_ref_clk);
        i_rd <= 1'b0;
        #1;
        chk("rdata", o_rdata, exp);
    endtask

    // Synchroniser plus routing register settle well within this
    task automatic settle();
        repeat (4) @(posedge i_ref_clk);
        #1;
    endtask

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", check_count, miscompares);
        if (miscompares == 0 && check_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    always @(posedge i_ref_clk) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            stop_test();
        end
    end

    // ****************
    // Tests
    // ****************
    initial begin
        repeat (6) @(posedge i_ref_clk);
        i_reset_n <= 1'b1;
        rdchk(ad(BASE_BLOCKING, OFF_CTRL), 16'h0000);
        rdchk(ad(BASE_BLOCKING, OFF_PULL), 16'h0000);
        rdchk(ad(BASE_BLOCKING, OFF_PIN0_ROUTE), 16'h0000);
        rdchk(ad(BASE_BLOCKING, OFF_PIN3_ROUTE), 16'h0000);
        chk("connect", {12'h0, o_pin_buffer_connect}, 16'h0000);
        // Output path runs with every pin disconnected
        @(posedge i_ref_clk);
        i_port_out_value <= 3'h5;
        settle();
        chk("pin_out", {13'h0, o_port_pin_out}, 16'h0005);
        $display("test reset_and_idle done");
        foreach (words[k]) begin
            wr(ad(BASE_NONBLOCKING, OFF_CTRL), words[k]);
            ce = ctrl_apply(ce, words[k]);
            rdchk(ad(BASE_BLOCKING, OFF_CTRL), ce);
            chk("direction", {13'h0, o_pin_direction}, {13'h0, ce[6:4]});
            chk("connect", {12'h0, o_pin_buffer_connect}, {12'h0, ce[3:0]});
            chk("oe", {13'h0, o_port_pin_oe}, {13'h0, ce[6:4] & ce[2:0]});
        end
        wr(ad(BASE_BLOCKING, OFF_CTRL), 16'h7f0f, 1'b0);
        rdchk(ad(BASE_BLOCKING, OFF_CTRL), 16'h0000, 1'b0);
        rdchk(ad(BASE_BLOCKING, OFF_CTRL), ce);
        wr(ad(BASE_BLOCKING, OFF_CTRL), 16'h7f0f);
        ce = ctrl_apply(ce, 16'h7f0f);
        $display("test control_masks done");
        wr(ad(BASE_BLOCKING, OFF_PULL), 16'h00ff);
        rdchk(ad(BASE_BLOCKING, OFF_PULL), 16'h000f);
        chk("pullup", {13'h0, o_pullup_on}, 16'h0007);
        chk("pulldown", {15'h0, o_pin3_pulldown_on}, 16'h0001);
        wr(ad(BASE_NONBLOCKING, OFF_PULL), 16'h0005);
        chk("pullup", {13'h0, o_pullup_on}, 16'h0005);
        chk("pulldown", {15'h0, o_pin3_pulldown_on}, 16'h0000);
        wr(16'h0142, 16'h00ff);
        rdchk(ad(BASE_BLOCKING, OFF_PULL), 16'h0005);
        rdchk(16'h0142, 16'h0000);
        rdchk(ad(BASE_BLOCKING, 8'h4b), 16'h0000);
        // Clock enable low freezes the registers against a write
        i_clk_en <= 1'b0;
        wr(ad(BASE_BLOCKING, OFF_PULL), 16'h0000);
        i_clk_en <= 1'b1;
        rdchk(ad(BASE_BLOCKING, OFF_PULL), 16'h0005);
        $display("test pulls_and_decode done");
        ext_drive <= 4'hf;
        ext_level <= 4'ha;
        settle();
        rdchk(ad(BASE_NONBLOCKING, OFF_LEVEL), 16'h0002);
        wr(ad(BASE_BLOCKING, OFF_LEVEL), 16'hffff);
        rdchk(ad(BASE_NONBLOCKING, OFF_LEVEL), 16'h0002);
        wr(ad(BASE_BLOCKING, OFF_PIN3_ROUTE), 16'h00ff);
        rdchk(ad(BASE_BLOCKING, OFF_PIN3_ROUTE), 16'h0080);
        rdchk(ad(BASE_NONBLOCKING, OFF_LEVEL), 16'h000a);
        ext_drive <= 4'hb;
        settle();
        rdchk(ad(BASE_NONBLOCKING, OFF_LEVEL), 16'h000e);
        ext_drive <= 4'hf;
        ext_level <= 4'h5;
        settle();
        rdchk(ad(BASE_BLOCKING, OFF_LEVEL), 16'h0005);
        wr(ad(BASE_BLOCKING, OFF_CTRL), 16'h0100);
        settle();
        rdchk(ad(BASE_BLOCKING, OFF_LEVEL), 16'h0004);
        wr(ad(BASE_BLOCKING, OFF_CTRL), 16'h0101);
        $display("test level_readback done");
        for (int b = 1; b < 7; b++) begin
            wr(ad(BASE_BLOCKING, OFF_PIN0_ROUTE), 16'h0001 << b);
            settle();
            ec = 4'h0;
            if (b >= 3) ec[b - 3] = 1'b1;
            chk("capture", {12'h0, o_capture_in}, {12'h0, ec});
            chk("serial_rx", {15'h0, o_serial_rx}, {15'h0, b == 2});
            chk("lin_tx_in", {15'h0, o_lin_tx_in}, {15'h0, b == 1});
        end
        wr(ad(BASE_BLOCKING, OFF_PIN0_ROUTE), 16'h00ff);
        rdchk(ad(BASE_BLOCKING, OFF_PIN0_ROUTE), 16'h007e);
        ext_level <= 4'h0;
        settle();
        chk("routes", {10'h0, o_capture_in, o_serial_rx, o_lin_tx_in}, 16'h0000);
        $display("test routing done");
        ext_level <= 4'h9;
        wr(ad(BASE_BLOCKING, OFF_PIN3_ROUTE), 16'h0000);
        i_normal_mode <= 1'b0;
        settle();
        chk("connect", {12'h0, o_pin_buffer_connect}, {12'h0, ce[3], 3'h0});
        chk("oe", {13'h0, o_port_pin_oe}, 16'h0000);
        chk("routes", {10'h0, o_capture_in, o_serial_rx, o_lin_tx_in}, 16'h0000);
        rdchk(ad(BASE_BLOCKING, OFF_LEVEL), 16'h0008);
        chk("pullup", {13'h0, o_pullup_on}, 16'h0005);
        i_normal_mode <= 1'b1;
        $display("test low_power done");
        stop_test();
    end
endmodule // gpio_port_config_regs_bench
